//--- rtl/atrb_bank.sv
/*
  trim register bank: offset trim for core 5, fine gain trims for cores
  0 to 5, pair-selected gains for cores 2 and 3, fuse defaults.
  assumes synchronous register port, fuse data valid while load pulses.
*/
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - 12-bit rw offset trim for core 5, bits 11:0, applied to core 5
// - 5-bit rw gain trims bits 4:0 for cores 0,1,4,5, own core only
// - core 2 uses first gain on pair a, second on pair b
// - core 3 uses first gain on pair c, second on pair d
// - trim defaults come from fuse storage on i_fuse_load; reset loads fixed zero
module atrb_bank (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_ce,
  input  wire logic [atrb_pkg::ADDR_W-1:0]   i_addr,
  input  wire logic [atrb_pkg::DATA_W-1:0]   i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [atrb_pkg::DATA_W-1:0]   o_rdata,
  input  wire logic                          i_fuse_load,
  input  wire atrb_pkg::atrb_fuse_s          i_fuse,
  input  wire logic                          i_core2_pair_b,
  input  wire logic                          i_core3_pair_d,
  output atrb_pkg::atrb_trim_s               o_trim
);

  // ********************************************************************
  // request decode
  // ********************************************************************
  atrb_pkg::atrb_req_s req;
  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  wire logic hit_ofs  = (req.addr == atrb_pkg::ADDR_OFFSET_TRIM_CORE5);
  wire logic hit_gain = (req.addr >= atrb_pkg::ADDR_GAIN_TRIM_CORE0) &&
                        (req.addr <= atrb_pkg::ADDR_GAIN_TRIM_CORE5);
  wire logic [atrb_pkg::ADDR_W-1:0] gain_off =
    req.addr - atrb_pkg::ADDR_GAIN_TRIM_CORE0;
  wire logic [atrb_pkg::GAIN_IDX_W-1:0] gain_idx =
    gain_off[atrb_pkg::GAIN_IDX_W-1:0];
  wire logic we_ofs  = req.wr && hit_ofs;
  wire logic we_gain = req.wr && hit_gain;

  // ********************************************************************
  // offset trim, core 5
  // ********************************************************************
  // reserved bits are not stored; software keeps them zero
  logic [atrb_pkg::OFS_W-1:0] offset_trim_core5_r;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      offset_trim_core5_r <= atrb_pkg::OFS_RESET;
    end else if (i_ce && i_fuse_load) begin
      offset_trim_core5_r <= i_fuse.offset_trim_core5;
    end else if (i_ce && we_ofs) begin
      offset_trim_core5_r <= req.wdata[atrb_pkg::OFS_W-1:0];
    end
  end

  // ********************************************************************
  // gain trims
  // ********************************************************************
  logic [atrb_pkg::GAIN_W-1:0]                  gain_rd;
  logic [atrb_pkg::NUM_GAIN*atrb_pkg::GAIN_W-1:0] gain_all;

  atrb_gain_mem i_atrb_gain_mem (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_ce      (i_ce),
    .i_load    (i_fuse_load),
    .i_fuse    (i_fuse.gain),
    .i_we      (we_gain),
    .i_idx     (gain_idx),
    .i_wdata   (req.wdata[atrb_pkg::GAIN_W-1:0]),
    .o_rdata   (gain_rd),
    .o_all     (gain_all)
  );

  // ********************************************************************
  // readback, one cycle after the read strobe
  // ********************************************************************
  logic sel_ofs_r;
  logic sel_gain_r;
  logic [atrb_pkg::OFS_W-1:0] ofs_rd_r;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_ofs_r  <= 1'b0;
      sel_gain_r <= 1'b0;
      ofs_rd_r   <= atrb_pkg::OFS_RESET;
    end else if (i_ce) begin
      sel_ofs_r  <= req.rd && hit_ofs;
      sel_gain_r <= req.rd && hit_gain;
      ofs_rd_r   <= offset_trim_core5_r;
    end
  end

  // unmapped or idle reads return zero; reserved bits read zero
  assign o_rdata = sel_ofs_r  ? {4'h0, ofs_rd_r} :
                   sel_gain_r ? {11'h000, gain_rd} :
                   atrb_pkg::RDATA_RESET;

  // ********************************************************************
  // trims to the converter cores, live from storage
  // ********************************************************************
  function automatic logic [atrb_pkg::GAIN_W-1:0] gsel(input int i);
    gsel = gain_all[i*atrb_pkg::GAIN_W +: atrb_pkg::GAIN_W];
  endfunction

  // no pipeline: a write takes effect on the next conversion
  wire logic [atrb_pkg::NUM_CORES*atrb_pkg::GAIN_W-1:0] core_gain = {
    gsel(7),                                 // core 5
    gsel(6),                                 // core 4
    i_core3_pair_d ? gsel(5) : gsel(4),
    i_core2_pair_b ? gsel(3) : gsel(2),
    gsel(1),                                 // core 1
    gsel(0)                                  // core 0
  };

  // one driver for the whole carrier
  assign o_trim = '{offset_trim_core5: offset_trim_core5_r, gain: core_gain};

endmodule // atrb_bank

`default_nettype wire

//--- rtl/atrb_pkg.sv
/*
  constants and carrier types for the converter trim register bank.
  assumes a byte-addressed register port on the device register clock.
*/
`default_nettype none

package atrb_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [11:0] ADDR_OFFSET_TRIM_CORE5      = 12'h33e;
  localparam logic [11:0] ADDR_GAIN_TRIM_CORE0        = 12'h360;
  localparam logic [11:0] ADDR_GAIN_TRIM_CORE1        = 12'h361;
  localparam logic [11:0] ADDR_GAIN_TRIM_CORE2_PAIR_A = 12'h362;
  localparam logic [11:0] ADDR_GAIN_TRIM_CORE2_PAIR_B = 12'h363;
  localparam logic [11:0] ADDR_GAIN_TRIM_CORE3_PAIR_C = 12'h364;
  localparam logic [11:0] ADDR_GAIN_TRIM_CORE3_PAIR_D = 12'h365;
  localparam logic [11:0] ADDR_GAIN_TRIM_CORE4        = 12'h366;
  localparam logic [11:0] ADDR_GAIN_TRIM_CORE5        = 12'h367;

  // ********************************************************************
  // field layout and sizes
  // ********************************************************************
  localparam int          ADDR_W       = 12;
  localparam int          DATA_W       = 16;
  localparam int          OFS_W        = 12;
  localparam int          GAIN_W       = 5;
  localparam int          NUM_GAIN     = 8;
  localparam int          GAIN_IDX_W   = 3;
  localparam int          NUM_CORES    = 6;
  localparam logic [11:0] OFS_RESET    = 12'h000;
  localparam logic [4:0]  GAIN_RESET   = 5'h00;
  localparam logic [15:0] RDATA_RESET  = 16'h0000;

  // ********************************************************************
  // carrier types
  // ********************************************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } atrb_req_s;

  // fuse defaults: one offset, eight gains flattened
  typedef struct packed {
    logic [OFS_W-1:0]           offset_trim_core5;
    logic [NUM_GAIN*GAIN_W-1:0] gain;
  } atrb_fuse_s;

  // trims as seen by the converter cores, one gain per core
  typedef struct packed {
    logic [OFS_W-1:0]            offset_trim_core5;
    logic [NUM_CORES*GAIN_W-1:0] gain;
  } atrb_trim_s;

endpackage : atrb_pkg

`default_nettype wire

//--- rtl/atrb_gain_mem.sv
/*
  eight-entry storage for the 5-bit fine gain trims with registered read.
  assumes the bank in front of it decodes addresses and qualifies writes.
*/
`timescale 1ns/1ns
`default_nettype none

module atrb_gain_mem (
  input  wire logic                                         i_clk_sys,
  input  wire logic                                         i_reset_n,
  input  wire logic                                         i_ce,
  input  wire logic                                         i_load,
  input  wire logic [atrb_pkg::NUM_GAIN*atrb_pkg::GAIN_W-1:0] i_fuse,
  input  wire logic                                         i_we,
  input  wire logic [atrb_pkg::GAIN_IDX_W-1:0]              i_idx,
  input  wire logic [atrb_pkg::GAIN_W-1:0]                  i_wdata,
  output logic      [atrb_pkg::GAIN_W-1:0]                  o_rdata,
  output logic      [atrb_pkg::NUM_GAIN*atrb_pkg::GAIN_W-1:0] o_all
);

  // ********************************************************************
  // entries
  // ********************************************************************
  // one register per entry keeps a single driver for every stored bit
  wire logic [atrb_pkg::GAIN_W-1:0] mem_w [atrb_pkg::NUM_GAIN];

  genvar g;
  generate
    for (g = 0; g < atrb_pkg::NUM_GAIN; g++) begin : g_entry
      logic [atrb_pkg::GAIN_W-1:0] entry_r;
      wire logic hit = i_we && (i_idx == (atrb_pkg::GAIN_IDX_W)'(g));
      always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
          entry_r <= atrb_pkg::GAIN_RESET;
        end else if (i_ce && i_load) begin
          entry_r <= i_fuse[g*atrb_pkg::GAIN_W +: atrb_pkg::GAIN_W];
        end else if (i_ce && hit) begin
          entry_r <= i_wdata;
        end
      end
      assign mem_w[g] = entry_r;
      assign o_all[g*atrb_pkg::GAIN_W +: atrb_pkg::GAIN_W] = entry_r;
    end
  endgenerate

  // ********************************************************************
  // registered read port
  // ********************************************************************
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= atrb_pkg::GAIN_RESET;
    end else if (i_ce) begin
      o_rdata <= mem_w[i_idx];
    end
  end

endmodule // atrb_gain_mem

`default_nettype wire

//--- sim/atrb_bank_sva.sv
/* port checker for the trim register bank.
   assumes one clock domain and a bind onto atrb_bank. */
`timescale 1ns/1ns
`default_nettype none
module atrb_bank_sva (
  input wire logic                 i_clk_sys,
  input wire logic                 i_reset_n,
  input wire logic                 i_ce,
  input wire logic [11:0]          i_addr,
  input wire logic [15:0]          i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire logic [15:0]          o_rdata,
  input wire logic                 i_fuse_load,
  input wire atrb_pkg::atrb_fuse_s i_fuse,
  input wire logic                 i_core2_pair_b,
  input wire logic                 i_core3_pair_d,
  input wire atrb_pkg::atrb_trim_s o_trim
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // fuse load wins, so it masks writes
  wire logic wr_ok = i_ce && i_wr && !i_fuse_load;
  a_ofs_write: assert property (wr_ok && i_addr == 12'h33e
    |=> o_trim.offset_trim_core5 == $past(i_wdata[11:0])) else $error("offset lost");
  a_gain_write: assert property (wr_ok && i_addr == 12'h367
    |=> o_trim.gain[29:25] == $past(i_wdata[4:0])) else $error("gain lost");
  a_core2_pair: assert property (wr_ok && i_addr == 12'h362
    && !i_core2_pair_b ##1 !i_core2_pair_b
    |-> o_trim.gain[14:10] == $past(i_wdata[4:0])) else $error("core2 sel");
  a_core3_pair: assert property (wr_ok && i_addr == 12'h365
    && i_core3_pair_d ##1 i_core3_pair_d
    |-> o_trim.gain[19:15] == $past(i_wdata[4:0])) else $error("core3 sel");
  a_fuse_load: assert property (i_ce && i_fuse_load |=>
    o_trim.offset_trim_core5 == $past(i_fuse.offset_trim_core5)) else $error("fuse not loaded");
  a_read_back: assert property (i_ce && i_rd && !i_fuse_load
    && i_addr == 12'h360 |=> o_rdata == {11'h000, $past(o_trim.gain[4:0])})
    else $error("readback wrong");
  a_rdata_idle: assert property ($past(i_ce) && !$past(i_rd)
    |-> o_rdata == 16'h0000) else $error("read data not idle");
  a_trim_hold: assert property (i_ce && !i_wr && !i_fuse_load
    ##1 $stable(i_core2_pair_b) && $stable(i_core3_pair_d)
    |-> $stable(o_trim)) else $error("trim moved");
endmodule // atrb_bank_sva
bind atrb_bank atrb_bank_sva i_atrb_bank_sva (.i_clk_sys(i_clk_sys),
  .i_reset_n(i_reset_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_fuse_load(i_fuse_load),
  .i_fuse(i_fuse), .i_core2_pair_b(i_core2_pair_b),
  .i_core3_pair_d(i_core3_pair_d), .o_trim(o_trim));
`default_nettype wire

//--- sim/atrb_bank_test.sv
/* self-checking bench for the trim register bank.
   assumes the checker is bound in; 250 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module atrb_bank_test;
  logic                 i_clk_sys, i_reset_n, i_ce, i_wr, i_rd, i_fuse_load;
  logic                 i_core2_pair_b, i_core3_pair_d;
  logic [11:0]          i_addr, ofs;
  logic [15:0]          i_wdata, o_rdata, q;
  logic [4:0]           g [8];
  atrb_pkg::atrb_fuse_s i_fuse;
  atrb_pkg::atrb_trim_s o_trim;
  int                   error_cnt, n_checks;
  atrb_bank i_atrb_bank (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_fuse_load(i_fuse_load),
    .i_fuse(i_fuse), .i_core2_pair_b(i_core2_pair_b),
    .i_core3_pair_d(i_core3_pair_d), .o_trim(o_trim));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t: seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask
  // every register read back, then the trims under both pair selects
  task automatic check_all;
    for (int i = 0; i < 9; i++) begin
      rd((i == 0) ? 12'h33e : 12'h35f + 12'(i), q);
      chk(64'(q), (i == 0) ? 64'(ofs) : 64'(g[i-1]));
    end
    for (int p = 0; p < 2; p++) begin
      @(posedge i_clk_sys);
      i_core2_pair_b <= p[0];
      i_core3_pair_d <= p[0];
      @(posedge i_clk_sys);
      #1 chk(64'(o_trim), 64'({ofs, g[7], g[6], g[4+p], g[2+p], g[1],
        g[0]}));
    end
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_fuse;
    @(posedge i_clk_sys);
    i_fuse_load <= 1'b1;
    @(posedge i_clk_sys);
    i_fuse_load <= 1'b0;
    ofs = 12'h5a3;
    for (int k = 0; k < 8; k++) g[k] = 5'h09 + 5'(k);
    #1 chk(64'(o_trim.offset_trim_core5), 64'(ofs));
    check_all;
  endtask
  task automatic test_write;
    @(posedge i_clk_sys);
    i_core2_pair_b <= 1'b0;
    i_core3_pair_d <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      g[k] = 5'h11 + 5'(k);
      wr(12'h360 + 12'(k), 16'(g[k]));
    end
    ofs = 12'habc;
    wr(12'h33e, 16'(ofs));
    #1 chk(64'(o_trim.offset_trim_core5), 64'(ofs));
    check_all;
  endtask
  // frozen clock enable and an unmapped address must change nothing
  task automatic test_refuse;
    @(posedge i_clk_sys);
    i_ce <= 1'b0;
    wr(12'h360, 16'h001f);
    @(posedge i_clk_sys);
    i_ce <= 1'b1;
    wr(12'h368, 16'h001f);
    rd(12'h368, q);
    chk(64'(q), 64'h0);
    check_all;
  endtask
  initial begin
    {i_reset_n, i_wr, i_rd, i_fuse_load, i_core2_pair_b} = 5'h00;
    {i_core3_pair_d, i_addr, i_wdata, ofs} = 41'h0;
    i_ce = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    i_fuse.offset_trim_core5 = 12'h5a3;
    for (int k = 0; k < 8; k++) i_fuse.gain[5*k +: 5] = 5'h09 + 5'(k);
    for (int k = 0; k < 8; k++) g[k] = 5'h00;
    repeat (10) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    check_all;
    test_fuse;
    test_write;
    test_refuse;
    stop_test;
  end
  initial begin
    #20000;
    error_cnt++;
    stop_test;
  end
endmodule // atrb_bank_test
`default_nettype wire
